// ==== core/iexp_pkg.sv ====
// Purpose: shared constants, register map and carrier types of the interrupt expander
// Assumes: 32-bit apb data, one aligned word per register
// Notes: slot numbers and offsets are the only place these figures live
package iexp_pkg;

    localparam int NUM_SRC = 96;
    localparam int GRP_SIZE = 8;
    localparam int NUM_GRP = 12;
    localparam int NUM_USED = 45;
    localparam int NUM_EXT = 4;
    localparam int NUM_PIN = 3;
    localparam int CNT_W = 16;
    localparam int VEC_W = 32;
    localparam int SRC_W = 7;
    localparam int GRP_W = 4;
    localparam int IDX_W = 3;
    localparam int ADDR_W = 12;
    localparam int STAT_W = 5;
    localparam int CTX_CYCLES = 8;
    localparam logic [IDX_W-1:0] CTX_LAST = IDX_W'(CTX_CYCLES - 1);

    // slots wired to peripherals; the rest stay dead
    localparam logic [NUM_SRC-1:0] USED_SLOTS = {51'h0, 45'h1FFF_FFFF_FFFF};
    localparam int SLOT_TIMER0 = 0;
    localparam int SLOT_EXT_A = 3;
    localparam int SLOT_EXT_B = 4;

    // external channels and the pins behind them
    localparam int EXT_A = 0;
    localparam int EXT_B = 1;
    localparam int EXT_SH = 2;
    localparam int EXT_NMI = 3;
    localparam int PIN_SH = 2;
    localparam int EXT_EN_LSB = 0;
    localparam int EXT_POL_LSB = 4;
    localparam int STAT_VEC = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_GRP_MASK = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_GRP_ACK = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_EXT_CTRL = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_EXT_CNT = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_SRC_EN = 12'h040;
    localparam logic [ADDR_W-1:0] OFS_SRC_FLAG = 12'h080;
    localparam logic [ADDR_W-1:0] OFS_VEC_BASE = 12'h200;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SAVE = 2'h1
    } iexp_state_e;

    typedef struct packed {
        logic valid;
        logic [GRP_W-1:0] grp;
    } iexp_ack_s;

    typedef struct packed {
        logic valid;
        logic [SRC_W-1:0] src;
        logic [VEC_W-1:0] vector;
    } iexp_vec_s;

endpackage

// ==== core/iexp_top.sv ====
// Purpose: peripheral interrupt expander with external edge interrupts and apb registers
// Assumes: peripheral requests are on pclk; external pins are asynchronous
// Notes: vector ram has no reset, software loads it before enabling sources
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps

module iexp_top
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [iexp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request sources
    input wire logic [iexp_pkg::NUM_SRC-1:0] periph_irq,
    input wire logic timer0_irq,
    // external pins
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire logic ext_nmi_shared_pin,
    // cpu side
    output logic [iexp_pkg::NUM_GRP-1:0] cpu_irq_line,
    input wire iexp_pkg::iexp_ack_s cpu_ack,
    output iexp_pkg::iexp_vec_s cpu_vec,
    output logic ctx_done,
    output logic ext_irq_shared,
    output logic ext_nonmaskable_irq,
    // interrupt to system
    output logic irq
);
    import iexp_pkg::*;

    function automatic logic in_rng(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                                    input int n);
        return (a >= base) && (int'(a) < int'(base) + 4 * n) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [ADDR_W-1:0] word_idx(input logic [ADDR_W-1:0] a,
                                                   input logic [ADDR_W-1:0] base);
        return (a - base) >> 2;
    endfunction

    // lowest set bit wins; msb of result flags a hit
    function automatic logic [IDX_W:0] first_set(input logic [GRP_SIZE-1:0] v);
        logic [IDX_W:0] r;
        r = '0;
        for (int i = GRP_SIZE - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = {1'b1, IDX_W'(i)};
            end
        end
        return r;
    endfunction

    logic [NUM_PIN-1:0] pin_s1, pin_s2, pin_s3, pin_lvl, pin_lvl_q;
    logic [NUM_EXT-1:0] ext_en, ext_pol;
    logic [CNT_W-1:0] ext_cnt [NUM_PIN];
    logic [NUM_SRC-1:0] src_flag, src_en, slot_inject;
    logic [NUM_GRP-1:0] grp_mask, grp_ack;
    logic [VEC_W-1:0] vec_ram [NUM_SRC];
    logic [STAT_W-1:0] irq_status, irq_mask;
    logic [IDX_W-1:0] ctx_cnt;
    iexp_state_e state;

    // external pins: three flops, a level counts once stages two and three agree
    wire [NUM_PIN-1:0] pins = {ext_nmi_shared_pin, ext_irq_b_pin, ext_irq_a_pin};
    wire [NUM_PIN-1:0] pin_agree = pin_s2 ~^ pin_s3;
    wire [NUM_PIN-1:0] next_pin_lvl = (pin_agree & pin_s3) | (~pin_agree & pin_lvl);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            pin_lvl <= '0;
            pin_lvl_q <= '0;
        end
        else
        begin
            pin_s1 <= pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_lvl <= next_pin_lvl;
            pin_lvl_q <= pin_lvl;
        end
    end

    // the shared pin feeds both the shared maskable and the non-maskable channel
    wire [NUM_EXT-1:0] ch_cur = {pin_lvl[PIN_SH], pin_lvl};
    wire [NUM_EXT-1:0] ch_prev = {pin_lvl_q[PIN_SH], pin_lvl_q};
    wire [NUM_EXT-1:0] ext_edge = ext_en & (ch_cur ^ ch_prev) & ~(ch_cur ^ ext_pol);

    // time-stamp counters, one per maskable channel
    genvar gc;
    generate
        for (gc = 0; gc < NUM_PIN; gc++)
        begin : g_cnt
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    ext_cnt[gc] <= '0;
                else if (ext_edge[gc])
                    ext_cnt[gc] <= '0;
                else
                    ext_cnt[gc] <= ext_cnt[gc] + CNT_W'(1);
            end
        end
    endgenerate

    // apb decode; answer one cycle into the access phase
    wire apb_acc = psel & penable & ~pready;
    wire apb_done = psel & penable & pready;
    wire wr_done = apb_done & pwrite;
    wire hit_vec = in_rng(paddr, OFS_VEC_BASE, NUM_SRC);
    wire hit_en = in_rng(paddr, OFS_SRC_EN, NUM_GRP);
    wire hit_flag = in_rng(paddr, OFS_SRC_FLAG, NUM_GRP);
    wire hit_cnt = in_rng(paddr, OFS_EXT_CNT, NUM_PIN);
    wire hit_gmask = paddr == OFS_GRP_MASK;
    wire hit_gack = paddr == OFS_GRP_ACK;
    wire hit_ectl = paddr == OFS_EXT_CTRL;
    wire hit_stat = paddr == OFS_IRQ_STATUS;
    wire hit_imask = paddr == OFS_IRQ_MASK;
    wire addr_hit = hit_vec | hit_en | hit_flag | hit_cnt | hit_gmask | hit_gack | hit_ectl
                    | hit_stat | hit_imask;
    wire [SRC_W-1:0] vec_idx = SRC_W'(word_idx(paddr, OFS_VEC_BASE));
    wire [GRP_W-1:0] en_idx = GRP_W'(word_idx(paddr, OFS_SRC_EN));
    wire [GRP_W-1:0] flag_idx = GRP_W'(word_idx(paddr, OFS_SRC_FLAG));
    wire [1:0] cnt_idx = 2'(word_idx(paddr, OFS_EXT_CNT));

    wire [31:0] rd_data =
        hit_gmask ? 32'(grp_mask) :
        hit_gack ? 32'(grp_ack) :
        hit_ectl ? 32'({ext_pol, ext_en}) :
        hit_stat ? 32'(irq_status) :
        hit_imask ? 32'(irq_mask) :
        hit_cnt ? 32'(ext_cnt[cnt_idx]) :
        hit_en ? 32'(src_en[en_idx * GRP_SIZE +: GRP_SIZE]) :
        hit_flag ? 32'(src_flag[flag_idx * GRP_SIZE +: GRP_SIZE]) :
        hit_vec ? vec_ram[vec_idx] : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= apb_acc;
            prdata <= apb_acc ? rd_data : 32'h0000_0000;
            pslverr <= apb_acc & ~addr_hit;
        end
    end

    // service: lowest pending enabled slot of the acknowledged group wins
    wire ack_take = cpu_ack.valid && (state == ST_IDLE) && (int'(cpu_ack.grp) < NUM_GRP);
    wire [GRP_SIZE-1:0] pend_sel = src_flag[cpu_ack.grp * GRP_SIZE +: GRP_SIZE]
                                   & src_en[cpu_ack.grp * GRP_SIZE +: GRP_SIZE];
    wire [IDX_W:0] win = first_set(pend_sel);
    wire win_hit = win[IDX_W];
    wire [IDX_W-1:0] win_idx = win[IDX_W-1:0];
    wire [SRC_W-1:0] win_src = {cpu_ack.grp, win_idx};

    // sources: timer and edge channels a/b injected into their slots
    always_comb
    begin
        slot_inject = '0;
        slot_inject[SLOT_TIMER0] = timer0_irq;
        slot_inject[SLOT_EXT_A] = ext_edge[EXT_A];
        slot_inject[SLOT_EXT_B] = ext_edge[EXT_B];
    end

    wire [NUM_SRC-1:0] src_in = (periph_irq | slot_inject) & USED_SLOTS;
    wire [NUM_SRC-1:0] flag_clr = (ack_take && win_hit) ? (NUM_SRC'(1) << win_src) : '0;
    // set beats clear so a request landing on its own service is kept
    wire [NUM_SRC-1:0] next_src_flag = src_in | (src_flag & ~flag_clr);

    logic [NUM_GRP-1:0] grp_any_en, grp_req;
    genvar gg;
    generate
        for (gg = 0; gg < NUM_GRP; gg++)
        begin : g_grp
            assign grp_any_en[gg] = |(src_flag[gg * GRP_SIZE +: GRP_SIZE]
                                     & src_en[gg * GRP_SIZE +: GRP_SIZE]);
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    src_en[gg * GRP_SIZE +: GRP_SIZE] <= '0;
                else if (wr_done && hit_en && (int'(en_idx) == gg))
                    src_en[gg * GRP_SIZE +: GRP_SIZE] <= pwdata[GRP_SIZE-1:0];
            end
        end
    endgenerate
    assign grp_req = grp_any_en & grp_mask & ~grp_ack;

    // group ack blocks further requests until software writes one to clear it
    wire [NUM_GRP-1:0] ack_set = ack_take ? (NUM_GRP'(1) << cpu_ack.grp) : '0;
    wire [NUM_GRP-1:0] ack_clr = (wr_done && hit_gack) ? pwdata[NUM_GRP-1:0] : '0;
    wire stat_rd = apb_done && !pwrite && hit_stat;
    // clear only what the read reported, so a later event survives
    wire [STAT_W-1:0] stat_clr = stat_rd ? prdata[STAT_W-1:0] : '0;
    wire [STAT_W-1:0] stat_ev = {ack_take, ext_edge};
    wire [STAT_W-1:0] next_status = stat_ev | (irq_status & ~stat_clr);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_flag <= '0;
            grp_ack <= '0;
            grp_mask <= '0;
            ext_en <= '0;
            ext_pol <= '0;
            irq_mask <= '0;
            irq_status <= '0;
        end
        else
        begin
            src_flag <= next_src_flag;
            grp_ack <= ack_set | (grp_ack & ~ack_clr);
            irq_status <= next_status;
            if (wr_done && hit_gmask)
                grp_mask <= pwdata[NUM_GRP-1:0];
            if (wr_done && hit_ectl)
            begin
                ext_en <= pwdata[EXT_EN_LSB +: NUM_EXT];
                ext_pol <= pwdata[EXT_POL_LSB +: NUM_EXT];
            end
            if (wr_done && hit_imask)
                irq_mask <= pwdata[STAT_W-1:0];
        end
    end

    // vector ram, writable any time including during service
    always_ff @(posedge pclk)
    begin
        if (wr_done && hit_vec)
            vec_ram[vec_idx] <= pwdata;
    end

    // service sequence: vector out next cycle, context save done eight cycles after take
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
            ctx_cnt <= '0;
            ctx_done <= 1'b0;
            cpu_vec <= '0;
        end
        else
        begin
            cpu_vec.valid <= ack_take;
            ctx_done <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (ack_take)
                    begin
                        cpu_vec.src <= win_src;
                        cpu_vec.vector <= vec_ram[win_src];
                        ctx_cnt <= IDX_W'(1);
                        state <= ST_SAVE;
                    end
                end
                ST_SAVE:
                begin
                    ctx_cnt <= ctx_cnt + IDX_W'(1);
                    if (ctx_cnt == CTX_LAST)
                    begin
                        ctx_done <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_irq_line <= '0;
            ext_irq_shared <= 1'b0;
            ext_nonmaskable_irq <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            cpu_irq_line <= grp_req;
            ext_irq_shared <= ext_edge[EXT_SH];
            ext_nonmaskable_irq <= ext_edge[EXT_NMI];
            irq <= |(irq_status & irq_mask);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_take;
        ack_take;
    endsequence
    sequence seq_service;
        cpu_vec.valid ##7 ctx_done;
    endsequence

    chk_service_eight: assert property (seq_take |-> ##1 seq_service)
        else $error("service did not finish in eight cycles");
    chk_prio_lowest: assert property (ack_take && win_hit |->
        ((pend_sel & ~({GRP_SIZE{1'b1}} << win_idx)) == '0) && pend_sel[win_idx])
        else $error("winner is not lowest pending slot");
    chk_src_disabled: assert property ((cpu_irq_line & ~$past(grp_any_en)) == '0)
        else $error("group line without enabled pending source");
    chk_unused_quiet: assert property ((src_flag & ~USED_SLOTS) == '0)
        else $error("unused slot went active");
    chk_timer_route: assert property (timer0_irq |=> src_flag[SLOT_TIMER0])
        else $error("timer request not latched in its slot");
    chk_group_line: assert property (cpu_irq_line[0] |-> $past(|src_flag[GRP_SIZE-1:0]))
        else $error("first group line without request in its group");
    chk_cnt_clear: assert property (ext_edge[EXT_A] |=> ext_cnt[EXT_A] == '0)
        else $error("counter not cleared on edge");
    chk_cnt_run: assert property (!ext_edge[EXT_B] |=>
        ext_cnt[EXT_B] == CNT_W'($past(ext_cnt[EXT_B]) + CNT_W'(1)))
        else $error("counter did not count up");
    chk_edge_pol: assert property (ext_edge[EXT_A] |->
        ext_en[EXT_A] && (pin_lvl[EXT_A] == ext_pol[EXT_A]))
        else $error("edge against polarity or disabled");
    chk_nmi_pin: assert property (ext_nonmaskable_irq |->
        $past(pin_lvl[PIN_SH]) != $past(pin_lvl_q[PIN_SH]))
        else $error("nmi without change on shared pin");
    chk_sync_agree: assert property ($rose(pin_lvl[EXT_A]) |->
        $past(pin_s2[EXT_A]) && $past(pin_s3[EXT_A]))
        else $error("level taken before stages agreed");

endmodule

// ==== sim/iexp_cpu_model.sv ====
// Purpose: cpu side model that takes grouped request lines and services them
// Assumes: one service in flight, the lowest raised line is served first
// Notes: grp is scrambled whenever no request stands, so a stale group never reads as valid
`timescale 1ns/1ps

module iexp_cpu_model
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // cpu side
    input wire logic [iexp_pkg::NUM_GRP-1:0] cpu_irq_line,
    input wire iexp_pkg::iexp_vec_s cpu_vec,
    input wire logic ctx_done,
    output iexp_pkg::iexp_ack_s cpu_ack
);
    import iexp_pkg::*;
    logic [1:0] phase;
    logic [GRP_W-1:0] pick;

    always_comb
    begin
        pick = '0;
        for (int g = NUM_GRP - 1; g >= 0; g--)
            if (cpu_irq_line[g])
                pick = GRP_W'(g);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= 2'h0;
            cpu_ack <= '0;
        end
        else if (phase == 2'h0)
        begin
            // one assignment per edge: scramble only while no line stands
            if (|cpu_irq_line)
            begin
                cpu_ack <= '{valid: 1'b1, grp: pick};
                phase <= 2'h1;
            end
            else
                cpu_ack.grp <= ~cpu_ack.grp;
        end
        else if (phase == 2'h1)
        begin
            // request held until the vector shows up
            if (cpu_vec.valid)
            begin
                cpu_ack.valid <= 1'b0;
                cpu_ack.grp <= ~cpu_ack.grp;
                phase <= 2'h2;
            end
        end
        else
        begin
            cpu_ack.grp <= ~cpu_ack.grp;
            if (ctx_done)
                phase <= 2'h0;
        end
    end
endmodule

// ==== sim/tb.sv ====
// Purpose: self-checking bench of the interrupt expander
// Assumes: apb master waits on pready; cpu model acks every raised line
// Notes: service results are queued by the driver and popped by the output monitor
`timescale 1ns/1ps

`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
    $display("BAD %0t got %h want %h", $time, a, e); end end

module tb;
    import iexp_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic timer0_irq = 1'b0, ext_irq_a_pin = 1'b0, ext_irq_b_pin = 1'b0;
    logic ext_nmi_shared_pin = 1'b1;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, se, ctx_done, ext_irq_shared, ext_nonmaskable_irq, irq;
    logic [NUM_SRC-1:0] periph_irq = '0;
    logic [NUM_GRP-1:0] cpu_irq_line;
    logic [VEC_W-1:0] v1, v2;
    iexp_ack_s cpu_ack;
    iexp_vec_s cpu_vec, exp_v;
    iexp_vec_s expq[$];
    int err_total = 0, samples_checked = 0, cyc = 0, vec_cyc = 0, n_sh = 0, n_nmi = 0;
    int s, b1, b2;

    iexp_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .periph_irq, .timer0_irq, .ext_irq_a_pin, .ext_irq_b_pin,
        .ext_nmi_shared_pin, .cpu_irq_line, .cpu_ack, .cpu_vec, .ctx_done, .ext_irq_shared,
        .ext_nonmaskable_irq, .irq);
    iexp_cpu_model cpu (.pclk, .presetn, .cpu_irq_line, .cpu_vec, .ctx_done, .cpu_ack);

    initial
    begin
        forever #50 pclk = ~pclk;
    end

    task automatic end_sim();
        $display("counts: %0d checked, %0d bad", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // answer latency is the slave's business, the loop only caps a hang
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            err_total++;
            end_sim();
        end
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_ctx();
        int n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (ctx_done !== 1'b1 && n < 100);
        if (n >= 100)
        begin
            err_total++;
            end_sim();
        end
    endtask

    task automatic pulse(input logic [NUM_SRC-1:0] m, input logic t);
        @(posedge pclk);
        periph_irq <= m;
        timer0_irq <= t;
        @(posedge pclk);
        periph_irq <= '0;
        timer0_irq <= 1'b0;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (ext_irq_shared === 1'b1)
            n_sh++;
        if (ext_nonmaskable_irq === 1'b1)
            n_nmi++;
        if (cpu_vec.valid === 1'b1)
        begin
            vec_cyc = cyc;
            exp_v = expq.size() > 0 ? expq.pop_front() : '0;
            `CHK(cpu_vec.src, exp_v.src)
            `CHK(cpu_vec.vector, exp_v.vector)
        end
        if (ctx_done === 1'b1)
            `CHK(cyc - vec_cyc, 7)
    end

    initial
    begin
        repeat (60000) @(posedge pclk);
        err_total++;
        end_sim();
    end

    initial
    begin
        void'($urandom(10527));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            s = $urandom_range(95, 0);
            v1 = $urandom();
            apb(1'b1, OFS_VEC_BASE + ADDR_W'(4 * s), v1);
            apb(1'b0, OFS_VEC_BASE + ADDR_W'(4 * s), 32'h0);
            `CHK(rd, v1)
        end
        apb(1'b0, OFS_VEC_BASE + ADDR_W'(4 * NUM_SRC), 32'h0);
        `CHK(se, 1'b1)
        $display("test vector_ram done");
        v1 = $urandom();
        apb(1'b1, OFS_VEC_BASE + ADDR_W'(4 * 10), v1);
        apb(1'b1, OFS_GRP_MASK, 32'h0000_0006);
        pulse(NUM_SRC'(1) << 10, 1'b0);
        repeat (6) @(posedge pclk);
        `CHK(cpu_irq_line, 12'h000)
        expq.push_back('{valid: 1'b1, src: 7'h0A, vector: v1});
        apb(1'b1, OFS_SRC_EN + 12'h004, 32'h0000_0004);
        wait_ctx();
        `CHK(expq.size(), 0)
        $display("test single_service done");
        v1 = $urandom();
        v2 = $urandom();
        apb(1'b1, OFS_VEC_BASE + ADDR_W'(4 * 17), v1);
        apb(1'b1, OFS_VEC_BASE + ADDR_W'(4 * 20), v2);
        apb(1'b1, OFS_SRC_EN + 12'h008, 32'h0000_0012);
        expq.push_back('{valid: 1'b1, src: 7'h11, vector: v1});
        expq.push_back('{valid: 1'b1, src: 7'h14, vector: v2});
        pulse((NUM_SRC'(1) << 17) | (NUM_SRC'(1) << 20), 1'b0);
        wait_ctx();
        apb(1'b0, OFS_GRP_ACK, 32'h0);
        `CHK(rd, 32'h0000_0006)
        apb(1'b1, OFS_GRP_ACK, 32'h0000_0004);
        wait_ctx();
        `CHK(expq.size(), 0)
        $display("test priority done");
        pulse({51'h7_FFFF_FFFF_FFFF, 45'h0}, 1'b1);
        for (int g = 5; g < NUM_GRP; g++)
        begin
            apb(1'b0, OFS_SRC_FLAG + ADDR_W'(4 * g), 32'h0);
            `CHK(rd, 32'h0)
        end
        apb(1'b0, OFS_SRC_FLAG, 32'h0);
        `CHK(rd, 32'h0000_0001)
        // slot enabled but its group masked off: the line must stay low
        apb(1'b1, OFS_SRC_EN, 32'h0000_0001);
        repeat (4) @(posedge pclk);
        `CHK(cpu_irq_line, 12'h000)
        v1 = $urandom();
        apb(1'b1, OFS_VEC_BASE, v1);
        expq.push_back('{valid: 1'b1, src: 7'h00, vector: v1});
        apb(1'b1, OFS_GRP_MASK, 32'h0000_0007);
        wait_ctx();
        `CHK(expq.size(), 0)
        $display("test dead_slots done");
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
        apb(1'b1, OFS_EXT_CTRL, 32'h0000_0011);
        repeat (30) @(posedge pclk);
        apb(1'b0, OFS_EXT_CNT, 32'h0);
        `CHK(rd >= 32'h14, 1'b1)
        ext_irq_a_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b0, OFS_EXT_CNT, 32'h0);
        `CHK(rd < 32'h14, 1'b1)
        apb(1'b0, OFS_SRC_FLAG, 32'h0);
        `CHK(rd[3], 1'b1)
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        `CHK(rd[4:0], 5'h11)
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        ext_irq_a_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        `CHK(rd[3:0], 4'h0)
        apb(1'b1, OFS_EXT_CTRL, 32'h0000_0022);
        ext_irq_b_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        `CHK(rd[3:0], 4'h2)
        apb(1'b0, OFS_EXT_CNT + 12'h004, 32'h0);
        `CHK(rd < 32'h14, 1'b1)
        $display("test ext_ab done");
        apb(1'b1, OFS_EXT_CTRL, 32'h0000_000C);
        b1 = n_sh;
        b2 = n_nmi;
        ext_nmi_shared_pin <= 1'b0;
        repeat (10) @(posedge pclk);
        ext_nmi_shared_pin <= 1'b1;
        repeat (10) @(posedge pclk);
        `CHK(n_sh - b1, 1)
        `CHK(n_nmi - b2, 1)
        apb(1'b1, OFS_EXT_CTRL, 32'h0000_0008);
        ext_nmi_shared_pin <= 1'b0;
        repeat (10) @(posedge pclk);
        `CHK(n_sh - b1, 1)
        `CHK(n_nmi - b2, 2)
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        `CHK(rd[3:0], 4'hC)
        $display("test shared_pin done");
        end_sim();
    end
endmodule
